/* hdl/mrbd_cfg.svh */
`ifndef MRBD_CFG_SVH
`define MRBD_CFG_SVH

// ---------------------------------------------------------------
// Sizes, thresholds and descriptor field positions.
// ---------------------------------------------------------------
`define MRBD_FIFO_WORDS 7
`define MRBD_BURST_WORDS 3'h4
`define MRBD_RX_REQ_WORDS 3'h4
`define MRBD_RX_REQ_SPACE 3'h3
`define MRBD_TX_SPACE_FULL 3'h4
`define MRBD_TX_SPACE_SHORT 3'h2
`define MRBD_BUF_WORDS 6'h20
`define MRBD_DESC_WRAP 1
`define MRBD_DESC_USED 0
`define MRBD_ST_EOF 15
`define MRBD_ST_SOF 14

`endif

/* hdl/mrbd_dma.sv */
`timescale 1ns/10ps
`include "mrbd_cfg.svh"

// ---------------------------------------------------------------
// Word FIFO with first-word fall-through output.
// ---------------------------------------------------------------
module mrbd_fifo #(
   parameter int W = 33,
   parameter int DEPTH = 16,
   parameter int CW = $clog2(DEPTH + 1)
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [CW-1:0] level
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [CW-1:0] cnt_r;
   logic wr;
   logic rd;

   // Full and empty come straight from the count, so neither can lie.
   assign in_ready = (cnt_r != FULL);
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign level = cnt_r;
   assign wr = in_valid && in_ready;
   assign rd = out_valid && out_ready;

   // Storage needs no reset; only the pointers and the count carry control state.
   always_ff @(posedge core_clk) begin
      if (wr) begin
         mem[wp_r] <= in_data;
      end
   end

   // Pointers wrap at the depth, which need not be a power of two.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (wr) begin
            wp_r <= (wp_r == LAST) ? '0 : wp_r + 1'b1;
         end
         if (rd) begin
            rp_r <= (rp_r == LAST) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + CW'(wr) - CW'(rd);
      end
   end
endmodule : mrbd_fifo

// ---------------------------------------------------------------
// Receive buffer manager and FIFO DMA of the ethernet_mac_unit.
// ---------------------------------------------------------------
module mrbd_dma
   import mrbd_pkg::*;
(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [31:0] rx_queue_base,
   input wire logic [1:0] cfg_rx_offset,
   input wire logic cfg_jumbo,
   input wire logic cfg_strip_fcs,
   input wire logic [31:0] rx_word,
   input wire logic [2:0] rx_word_bytes,
   input wire logic [2:0] rx_word_fcs,
   input wire logic rx_word_last,
   input wire logic rx_word_valid,
   output logic rx_word_ready,
   input wire logic rx_frame_bad,
   input wire logic rx_bcast,
   input wire logic rx_mhash,
   input wire logic rx_uhash,
   input wire logic rx_ext_match,
   input wire logic [3:0] rx_sa_match,
   input wire logic rx_type_match,
   input wire logic rx_vlan_tag,
   input wire logic rx_vlan_id_zero,
   input wire logic [2:0] rx_vlan_pri,
   input wire logic rx_vlan_cfi,
   output logic [31:0] rx_queue_ptr,
   output logic rx_buf_unavail,
   output logic rx_overrun,
   output logic rx_frame_done,
   input wire logic [31:0] tx_fetch_addr,
   input wire logic [11:0] tx_fetch_words,
   input wire logic tx_fetch_start,
   output logic tx_fetch_busy,
   output logic [31:0] tx_word,
   output logic tx_word_valid,
   input wire logic tx_word_ready,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [2:0] mem_len,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack
);
   function automatic logic [2:0] mrbd_min(input logic [2:0] a, input logic [2:0] b);
      mrbd_min = (a < b) ? a : b;
   endfunction : mrbd_min

   mrbd_state_e st_r;
   logic [55:0] acc_r;
   logic [2:0] accn_r;
   logic frame_open_r;
   logic flush_r;
   logic [13:0] len_r;
   logic stat_pend_r;
   logic bad_r;
   logic [1:0] off_r;
   logic [13:0] stat_len_r;
   logic [15:0] stat_hi_r;
   logic [9:0] idx_r;
   logic have_buf_r;
   logic [29:0] buf_addr_r;
   logic wrap_r;
   logic [5:0] widx_r;
   logic first_r;
   logic eof_seen_r;
   logic need_wb_r;
   logic [2:0] beat_r;
   logic [29:0] tx_addr_r;
   logic [11:0] tx_left_r;
   logic [32:0] rxf_in_data;
   logic rxf_in_valid;
   logic rxf_in_ready;
   logic [32:0] rxf_out_data;
   logic rxf_out_valid;
   logic rxf_out_ready;
   mrbd_lvl_t rxf_lvl;
   logic txf_in_valid;
   logic txf_in_ready;
   mrbd_lvl_t txf_lvl;
   logic accept;
   logic [2:0] keep;
   logic [31:0] wmask;
   logic [2:0] ec;
   logic [55:0] sum;
   logic [3:0] ncnt;
   logic [13:0] len_nxt;
   logic [31:0] desc_addr;
   logic [29:0] cur_w;
   logic [5:0] room;
   logic [2:0] roomc;
   logic [2:0] rx_blen;
   logic [2:0] tx_blen;
   logic [2:0] tx_free;
   logic rx_want;
   logic fetch_want;
   logic tx_want;
   logic last_beat;
   logic eof_now;
   logic [31:0] word0;
   logic [31:0] word1;

   // ---------------------------------------------------------------
   // Receive packer: folds bytes into words, offset first.
   // ---------------------------------------------------------------
   // Trailing FCS bytes are simply not kept, so length and data shrink together.
   assign keep = rx_word_bytes - (cfg_strip_fcs ? rx_word_fcs : 3'h0);
   assign wmask = ~(32'hFFFF_FFFF << {keep, 3'b000});
   // A new frame starts with the configured offset already counted as filler bytes.
   assign ec = frame_open_r ? accn_r : {1'b0, cfg_rx_offset};
   assign sum = (frame_open_r ? acc_r : 56'h0) | ({24'h0, rx_word & wmask} << {ec, 3'b000});
   assign ncnt = {1'b0, ec} + {1'b0, keep};
   assign len_nxt = (frame_open_r ? len_r : 14'h0) + {11'h0, keep};
   // A new frame waits until the previous one has its status written.
   assign rx_word_ready = rxf_in_ready && !flush_r && !stat_pend_r;
   assign accept = rx_word_valid && rx_word_ready;
   assign rxf_in_valid = flush_r || (accept && ncnt >= 4'h4);
   assign rxf_in_data = flush_r ? {1'b1, acc_r[31:0]} : {rx_word_last && ncnt == 4'h4, sum[31:0]};

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         acc_r <= '0;
         accn_r <= '0;
         frame_open_r <= 1'b0;
         flush_r <= 1'b0;
         len_r <= '0;
      end else if (flush_r) begin
         flush_r <= !rxf_in_ready;
      end else if (accept) begin
         frame_open_r <= !rx_word_last;
         flush_r <= rx_word_last && ncnt != 4'h4;
         len_r <= len_nxt;
         if (ncnt >= 4'h4) begin
            acc_r <= {32'h0, sum[55:32]};
            accn_r <= 3'(ncnt - 4'h4);
         end else begin
            acc_r <= sum;
            accn_r <= ncnt[2:0];
         end
      end
   end

   // Frame status is caught with the final word; address flags map to 31..16.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bad_r <= 1'b0;
         off_r <= '0;
         stat_len_r <= '0;
         stat_hi_r <= '0;
      end else if (accept) begin
         if (!frame_open_r) begin
            off_r <= cfg_rx_offset;
         end
         if (rx_word_last) begin
            bad_r <= rx_frame_bad;
            stat_len_r <= len_nxt;
            stat_hi_r <= {rx_bcast, rx_mhash, rx_uhash, rx_ext_match, 1'b0,
                          rx_sa_match[0], rx_sa_match[1], rx_sa_match[2], rx_sa_match[3],
                          rx_type_match, rx_vlan_tag, rx_vlan_tag && rx_vlan_id_zero,
                          rx_vlan_tag ? rx_vlan_pri : 3'h0, rx_vlan_tag && rx_vlan_cfi};
         end
      end
   end

   // Losing data here means the bus answered too late for the FIFO depth.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_overrun <= 1'b0;
      end else begin
         rx_overrun <= rx_word_valid && !rxf_in_ready;
      end
   end

   // ---------------------------------------------------------------
   // FIFOs of 28 bytes each way.
   // ---------------------------------------------------------------
   mrbd_fifo #(.W(33), .DEPTH(`MRBD_FIFO_WORDS)) u_rxf (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .in_data(rxf_in_data),
      .in_valid(rxf_in_valid),
      .in_ready(rxf_in_ready),
      .out_data(rxf_out_data),
      .out_valid(rxf_out_valid),
      .out_ready(rxf_out_ready),
      .level(rxf_lvl)
   );

   mrbd_fifo #(.W(32), .DEPTH(`MRBD_FIFO_WORDS)) u_txf (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .in_data(mem_rdata),
      .in_valid(txf_in_valid),
      .in_ready(txf_in_ready),
      .out_data(tx_word),
      .out_valid(tx_word_valid),
      .out_ready(tx_word_ready),
      .level(txf_lvl)
   );

   // ---------------------------------------------------------------
   // Burst sizing and bus request thresholds.
   // ---------------------------------------------------------------
   assign desc_addr = {rx_queue_base[31:2], 2'b00} + {19'h0, idx_r, 3'b000};
   assign rx_queue_ptr = desc_addr;
   assign cur_w = buf_addr_r + {24'h0, widx_r};
   assign room = `MRBD_BUF_WORDS - widx_r;
   assign roomc = (room >= 6'h4) ? `MRBD_BURST_WORDS : room[2:0];
   // Bursts stop at the buffer end and never cross a 16-byte line.
   assign rx_blen = mrbd_min(mrbd_min(`MRBD_BURST_WORDS, rxf_lvl),
                             mrbd_min(roomc, 3'h4 - {1'b0, cur_w[1:0]}));
   assign tx_blen = mrbd_min(mrbd_min(`MRBD_BURST_WORDS, (tx_left_r >= 12'h4) ? 3'h4 : tx_left_r[2:0]),
                             3'h4 - {1'b0, tx_addr_r[1:0]});
   // The frame tail and a nearly full buffer may go out below the threshold.
   assign rx_want = have_buf_r && !need_wb_r && room != 6'h0 && rxf_lvl != 3'h0 &&
                    ((rxf_lvl >= `MRBD_RX_REQ_WORDS && 3'(`MRBD_FIFO_WORDS) - rxf_lvl >= `MRBD_RX_REQ_SPACE) ||
                     rxf_lvl >= `MRBD_RX_REQ_WORDS || (stat_pend_r && !flush_r) || rxf_lvl >= roomc);
   assign fetch_want = !have_buf_r && rxf_out_valid;
   assign tx_free = 3'(`MRBD_FIFO_WORDS) - txf_lvl;
   assign tx_want = tx_left_r != 12'h0 && (tx_free >= `MRBD_TX_SPACE_FULL ||
                    (tx_free >= `MRBD_TX_SPACE_SHORT && tx_left_r <= 12'h2));
   assign tx_fetch_busy = tx_left_r != 12'h0;

   // ---------------------------------------------------------------
   // Bus master signalling.
   // ---------------------------------------------------------------
   assign mem_req = st_r == st_fetch || st_r == st_wdata || st_r == st_wback || st_r == st_txrd;
   assign mem_we = st_r == st_wdata || st_r == st_wback;
   assign last_beat = (beat_r + 3'h1) == mem_len;
   assign word0 = {buf_addr_r, wrap_r, 1'b1};
   // Overflowed buffers carry only start and offset; the last one the whole status.
   assign word1 = eof_seen_r ? {stat_hi_r, 1'b1, first_r, cfg_jumbo ? stat_len_r[13:12] : (first_r ? off_r : 2'h0),
                                stat_len_r[11:0]}
                             : {16'h0, 1'b0, first_r, first_r ? off_r : 2'h0, 12'h0};
   assign mem_wdata = (st_r == st_wback) ? ((beat_r == 3'h0) ? word0 : word1) : rxf_out_data[31:0];
   assign rxf_out_ready = (st_r == st_wdata && mem_ack) || st_r == st_drop;
   assign txf_in_valid = st_r == st_txrd && mem_ack;
   assign eof_now = eof_seen_r || rxf_out_data[32];

   // ---------------------------------------------------------------
   // Bus engine: fixed priority, one operation at a time.
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= st_idle;
         mem_addr <= '0;
         mem_len <= '0;
         beat_r <= '0;
      end else begin
         case (st_r)
            st_idle: begin
               beat_r <= 3'h0;
               if (need_wb_r) begin
                  st_r <= st_wback;
                  mem_addr <= desc_addr;
                  mem_len <= 3'h2;
               end else if (fetch_want) begin
                  st_r <= st_fetch;
                  mem_addr <= desc_addr;
                  mem_len <= 3'h1;
               end else if (tx_want) begin
                  st_r <= st_txrd;
                  mem_addr <= {tx_addr_r, 2'b00};
                  mem_len <= tx_blen;
               end else if (rx_want) begin
                  st_r <= st_wdata;
                  mem_addr <= {cur_w, 2'b00};
                  mem_len <= rx_blen;
               end
            end
            st_fetch: begin
               if (mem_ack) begin
                  st_r <= mem_rdata[`MRBD_DESC_USED] ? st_drop : st_idle;
               end
            end
            st_drop: begin
               if (rxf_out_valid && rxf_out_data[32]) begin
                  st_r <= st_idle;
               end
            end
            st_wdata, st_wback, st_txrd: begin
               if (mem_ack) begin
                  beat_r <= beat_r + 3'h1;
                  if (last_beat) begin
                     st_r <= st_idle;
                  end
               end
            end
            default: begin
               st_r <= st_idle;
            end
         endcase
      end
   end

   // Current buffer and its place in the descriptor list.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         idx_r <= '0;
         have_buf_r <= 1'b0;
         buf_addr_r <= '0;
         wrap_r <= 1'b0;
         widx_r <= '0;
         first_r <= 1'b1;
         eof_seen_r <= 1'b0;
         need_wb_r <= 1'b0;
         stat_pend_r <= 1'b0;
      end else begin
         if (accept && rx_word_last) begin
            stat_pend_r <= 1'b1;
         end
         if (st_r == st_fetch && mem_ack && !mem_rdata[`MRBD_DESC_USED]) begin
            have_buf_r <= 1'b1;
            buf_addr_r <= mem_rdata[31:2];
            wrap_r <= mem_rdata[`MRBD_DESC_WRAP];
            widx_r <= 6'h0;
         end
         if (st_r == st_drop && rxf_out_valid && rxf_out_data[32]) begin
            stat_pend_r <= 1'b0;
            first_r <= 1'b1;
         end
         if (st_r == st_wdata && mem_ack) begin
            widx_r <= widx_r + 6'h1;
            eof_seen_r <= eof_now;
            if (last_beat && eof_now && bad_r) begin
               // An errored frame gives its current buffer back for the next frame.
               widx_r <= 6'h0;
               first_r <= 1'b1;
               eof_seen_r <= 1'b0;
               stat_pend_r <= 1'b0;
            end else if (last_beat && (eof_now || widx_r + 6'h1 == `MRBD_BUF_WORDS)) begin
               need_wb_r <= 1'b1;
            end
         end
         if (st_r == st_wback && mem_ack && last_beat) begin
            need_wb_r <= 1'b0;
            have_buf_r <= 1'b0;
            idx_r <= wrap_r ? 10'h0 : idx_r + 10'h1;
            first_r <= eof_seen_r;
            eof_seen_r <= 1'b0;
            if (eof_seen_r) begin
               stat_pend_r <= 1'b0;
            end
         end
      end
   end

   // Event pulses toward the status and interrupt logic.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_buf_unavail <= 1'b0;
         rx_frame_done <= 1'b0;
      end else begin
         rx_buf_unavail <= st_r == st_fetch && mem_ack && mem_rdata[`MRBD_DESC_USED];
         rx_frame_done <= st_r == st_wback && mem_ack && last_beat && eof_seen_r;
      end
   end

   // Transmit fetch window; a start while busy is ignored.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_addr_r <= '0;
         tx_left_r <= '0;
      end else if (txf_in_valid) begin
         tx_addr_r <= tx_addr_r + 30'h1;
         tx_left_r <= tx_left_r - 12'h1;
      end else if (tx_fetch_start && tx_left_r == 12'h0) begin
         tx_addr_r <= tx_fetch_addr[31:2];
         tx_left_r <= tx_fetch_words;
      end
   end

   // ---------------------------------------------------------------
   // Assertions and coverage.
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   a_fifo_cap: assert property (txf_in_valid |-> txf_in_ready)
      else $error("Transmit FIFO written beyond 28 bytes.");
   a_burst_line: assert property (mem_req |-> mem_len != 3'h0 && {1'b0, mem_addr[3:2]} + mem_len <= 3'h4)
      else $error("Burst empty or crossing a 16-byte line.");
   a_rx_req_go: assert property (st_r == st_idle && rx_want && !need_wb_r && !fetch_want && !tx_want
                                 |=> st_r == st_wdata && mem_len == $past(rx_blen))
      else $error("Receive request not served.");
   a_tx_req_room: assert property ($rose(st_r == st_txrd) |-> $past(tx_free >= 3'h4 ||
                                   (tx_free >= 3'h2 && tx_left_r <= 12'h2)) && txf_in_ready)
      else $error("Transmit read without room.");
   a_buf_bound: assert property (widx_r <= 6'h20)
      else $error("Buffer write past 128 bytes.");
   a_wb_used: assert property (st_r == st_wback && beat_r == 3'h0 |-> mem_wdata[0] && mem_addr == desc_addr)
      else $error("Used flag missing or wrong descriptor.");
   a_wb_partial: assert property (st_r == st_wback && beat_r == 3'h1 && !eof_seen_r
                                  |-> mem_wdata[31:15] == 17'h0 && mem_wdata[11:0] == 12'h0)
      else $error("Partial status not cleared.");
   a_wrap_next: assert property (st_r == st_wback && mem_ack && last_beat && wrap_r |=> idx_r == 10'h0)
      else $error("Wrap did not restart the list.");
   a_used_drop: assert property (st_r == st_fetch && mem_ack && mem_rdata[0]
                                 |=> st_r == st_drop && rx_buf_unavail && !have_buf_r)
      else $error("Used buffer was taken.");

   c_whole_frame: cover property (st_r == st_wback && beat_r == 3'h1 && eof_seen_r && first_r);
   c_overflow: cover property (st_r == st_wback && beat_r == 3'h1 && !eof_seen_r);
   c_drop: cover property (st_r == st_drop);
   c_tx_short: cover property (st_r == st_txrd && mem_len == 3'h2);
endmodule : mrbd_dma

/* hdl/mrbd_pkg.sv */
package mrbd_pkg;
   // ---------------------------------------------------------------
   // Bus engine states.
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      st_idle = 3'h0,
      st_fetch = 3'h1,
      st_wdata = 3'h2,
      st_wback = 3'h3,
      st_txrd = 3'h4,
      st_drop = 3'h5
   } mrbd_state_e;
   typedef logic [2:0] mrbd_lvl_t;
endpackage : mrbd_pkg

/* verif/mrbd_mem_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------
// System memory behind the bus master port.
// ----------------------------------------------
module mrbd_mem_model (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [2:0] mem_len,
   input wire logic [31:0] mem_wdata,
   output logic [31:0] mem_rdata,
   output logic mem_ack
);
   logic [31:0] mem [0:4095];
   logic [2:0] beat_r;
   logic last_w;
   logic [11:0] idx;
   // The final beat is spotted so that no stray ack reaches the idle cycle.
   assign last_w = mem_ack && (beat_r == mem_len - 3'h1);
   assign idx = mem_addr[13:2] + 12'(beat_r);
   // Outside a beat the data lines show the inverse, so stale data never matches.
   assign mem_rdata = mem_ack ? mem[idx] : ~mem[idx];
   // Each requested cycle stalls with one chance in three, well inside the latency budget.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         beat_r <= 3'h0;
         mem_ack <= 1'h0;
      end else begin
         beat_r <= last_w ? 3'h0 : beat_r + 3'(mem_ack);
         mem_ack <= mem_req && !last_w && ($urandom_range(2) != 0);
      end
   end
   // Each acked write beat lands one word further on.
   always @(posedge core_clk) begin
      if (mem_ack && mem_we) mem[idx] <= mem_wdata;
   end
endmodule : mrbd_mem_model

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
   import mrbd_pkg::*;
   logic core_clk = 1'h0, arst_n = 1'h0, cfg_jumbo = 1'h0, cfg_strip_fcs = 1'h0, rx_word_last = 1'h0;
   logic [31:0] rx_queue_base = 32'h100, rx_word = 32'h0, tx_fetch_addr = 32'h0;
   logic [31:0] rx_queue_ptr, tx_word, mem_addr, mem_wdata, mem_rdata;
   logic [1:0] cfg_rx_offset = 2'h0;
   logic [2:0] rx_word_bytes = 3'h0, rx_word_fcs = 3'h0, rx_vlan_pri = 3'h0, mem_len;
   logic [3:0] rx_sa_match = 4'h0;
   logic [11:0] tx_fetch_words = 12'h0;
   logic rx_word_valid = 1'h0, rx_frame_bad = 1'h0, rx_bcast = 1'h0, rx_mhash = 1'h0, rx_uhash = 1'h0;
   logic rx_ext_match = 1'h0, rx_type_match = 1'h0, rx_vlan_tag = 1'h0, rx_vlan_id_zero = 1'h0;
   logic rx_vlan_cfi = 1'h0, tx_fetch_start = 1'h0, tx_word_ready = 1'h0;
   logic rx_word_ready, rx_buf_unavail, rx_overrun, rx_frame_done, tx_fetch_busy, tx_word_valid;
   logic mem_req, mem_we, mem_ack;
   int miscompares = 0, checks_done = 0, unav_n = 0;
   always #5 core_clk = ~core_clk;
   mrbd_dma mrbd_dma_i (.core_clk, .arst_n, .rx_queue_base, .cfg_rx_offset, .cfg_jumbo, .cfg_strip_fcs,
      .rx_word, .rx_word_bytes, .rx_word_fcs, .rx_word_last, .rx_word_valid, .rx_word_ready, .rx_frame_bad,
      .rx_bcast, .rx_mhash, .rx_uhash, .rx_ext_match, .rx_sa_match, .rx_type_match, .rx_vlan_tag,
      .rx_vlan_id_zero, .rx_vlan_pri, .rx_vlan_cfi, .rx_queue_ptr, .rx_buf_unavail, .rx_overrun,
      .rx_frame_done, .tx_fetch_addr, .tx_fetch_words, .tx_fetch_start, .tx_fetch_busy, .tx_word,
      .tx_word_valid, .tx_word_ready, .mem_req, .mem_we, .mem_addr, .mem_len, .mem_wdata, .mem_rdata, .mem_ack);
   mrbd_mem_model mrbd_mem_model_i (.core_clk, .arst_n, .mem_req, .mem_we, .mem_addr, .mem_len,
      .mem_wdata, .mem_rdata, .mem_ack);
   // ----------------------------------------------
   // Checking and closing.
   // ----------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic close_out;
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   // Flags above bit 15 appear only in a buffer that ends a frame.
   function automatic logic [31:0] st(input int len, input logic [1:0] off, input logic eof, sof, jb,
                                      input logic [14:0] r);
      logic [15:0] hi;
      hi = {r[3:0], 1'h0, r[4], r[5], r[6], r[7], r[8], r[9], r[9] & r[10], r[13:11], r[14]};
      return {eof ? hi : 16'h0, eof, sof, jb ? 2'(len >> 12) : (sof ? off : 2'h0), eof ? 12'(len) : 12'h0};
   endfunction : st
   // VLAN side fields are zeroed when no tag is present, since they mean nothing then.
   function automatic logic [14:0] rnd;
      logic [14:0] v;
      v = 15'($urandom);
      if (!v[9]) v[14:10] = 5'h0;
      return v;
   endfunction : rnd
   function automatic logic [31:0] mb(input int a);
      return 32'(mrbd_mem_model_i.mem[a[13:2]][8 * a[1:0] +: 8]);
   endfunction : mb
   // ----------------------------------------------
   // Receive stream driver: byte k of a frame is k xor 5A.
   // ----------------------------------------------
   task automatic send(input int len, input logic [1:0] off, input logic [14:0] r);
      int n, f, cnt;
      @(posedge core_clk);
      cfg_rx_offset <= off;
      for (int k = 0; k < len; k += 4) begin
         n = (len - k < 4) ? len - k : 4;
         f = (k + n > len - 4) ? k + n - ((k > len - 4) ? k : len - 4) : 0;
         rx_word <= {8'(k + 3), 8'(k + 2), 8'(k + 1), 8'(k)} ^ 32'h5A5A5A5A;
         rx_word_bytes <= 3'(n);
         rx_word_fcs <= 3'(f);
         rx_word_last <= (k + n == len);
         {rx_vlan_cfi, rx_vlan_pri, rx_vlan_id_zero, rx_vlan_tag, rx_type_match, rx_sa_match,
          rx_bcast, rx_mhash, rx_uhash, rx_ext_match} <= r;
         rx_word_valid <= 1'h1;
         cnt = 0;
         @(negedge core_clk);
         while (rx_word_ready !== 1'h1 && cnt < 3000) begin
            @(negedge core_clk);
            cnt++;
         end
         if (cnt >= 3000) miscompares++;
         @(posedge core_clk);
      end
      rx_word_valid <= 1'h0;
   endtask : send
   task automatic wait_done;
      int cnt;
      cnt = 0;
      while (rx_frame_done !== 1'h1 && cnt < 3000) begin
         @(negedge core_clk);
         cnt++;
      end
      chk("frame_done", 32'(rx_frame_done), 32'h1);
      @(posedge core_clk);
   endtask : wait_done
   always @(posedge core_clk) if (rx_buf_unavail === 1'h1) unav_n++;
   // ----------------------------------------------
   // Main sequence and watchdog.
   // ----------------------------------------------
   initial begin
      #400000;
      miscompares++;
      close_out();
   end
   initial begin
      logic [14:0] r;
      logic [31:0] tw [10];
      int i, cnt;
      void'($urandom(32'h18D5ABEE));
      for (i = 0; i < 4; i++) begin
         mrbd_mem_model_i.mem[64 + 2 * i] = 32'h400 + 32'h80 * i + ((i == 3) ? 32'h2 : 32'h0);
         mrbd_mem_model_i.mem[65 + 2 * i] = 32'h0;
      end
      repeat (6) @(posedge core_clk);
      chk("ptr_rst", rx_queue_ptr, 32'h100);
      arst_n <= 1'h1;
      r = rnd();
      send(200, 2'h2, r);
      wait_done();
      chk("st0", mrbd_mem_model_i.mem[65], st(200, 2'h2, 1'h0, 1'h1, 1'h0, r));
      chk("used0", mrbd_mem_model_i.mem[64], 32'h401);
      chk("st1", mrbd_mem_model_i.mem[67], st(200, 2'h2, 1'h1, 1'h0, 1'h0, r));
      for (i = 0; i < 200; i++) chk("byte", mb(i < 126 ? 32'h402 + i : 32'h480 + i - 126), 32'(8'(i) ^ 8'h5A));
      cfg_strip_fcs <= 1'h1;
      r = rnd();
      send(61, 2'h3, r);
      wait_done();
      chk("st2", mrbd_mem_model_i.mem[69], st(57, 2'h3, 1'h1, 1'h1, 1'h0, r));
      chk("b56", mb(32'h53B), 32'(8'h38 ^ 8'h5A));
      cfg_strip_fcs <= 1'h0;
      cfg_jumbo <= 1'h1;
      r = rnd();
      send(8, 2'h1, r);
      wait_done();
      chk("st3", mrbd_mem_model_i.mem[71], st(8, 2'h1, 1'h1, 1'h1, 1'h1, r));
      chk("ptr_wrap", rx_queue_ptr, 32'h100);
      cfg_jumbo <= 1'h0;
      send(20, 2'h0, rnd());
      repeat (100) @(posedge core_clk);
      chk("unavail", 32'(unav_n != 0), 32'h1);
      mrbd_mem_model_i.mem[64] = 32'h400;
      r = rnd();
      send(20, 2'h0, r);
      wait_done();
      chk("st_reuse", mrbd_mem_model_i.mem[65], st(20, 2'h0, 1'h1, 1'h1, 1'h0, r));
      // An errored frame must leave its buffer unused so the next frame lands there.
      mrbd_mem_model_i.mem[66] = 32'h480;
      rx_frame_bad <= 1'h1;
      send(20, 2'h0, rnd());
      repeat (60) @(posedge core_clk);
      chk("bad_kept", mrbd_mem_model_i.mem[66], 32'h480);
      rx_frame_bad <= 1'h0;
      r = rnd();
      send(24, 2'h1, r);
      wait_done();
      chk("st_recov", mrbd_mem_model_i.mem[67], st(24, 2'h1, 1'h1, 1'h1, 1'h0, r));
      chk("b_recov", mb(32'h481), 32'h5A);
      for (i = 0; i < 10; i++) begin
         tw[i] = $urandom;
         mrbd_mem_model_i.mem[768 + i] = tw[i];
      end
      @(posedge core_clk);
      tx_fetch_addr <= 32'hC00;
      tx_fetch_words <= 12'hA;
      tx_fetch_start <= 1'h1;
      @(posedge core_clk);
      tx_fetch_start <= 1'h0;
      repeat (100) @(posedge core_clk);
      chk("tx_held", 32'(tx_fetch_busy), 32'h1);
      i = 0;
      cnt = 0;
      while (i < 10 && cnt < 2000) begin
         @(posedge core_clk);
         tx_word_ready <= 1'($urandom);
         cnt++;
         @(negedge core_clk);
         if (tx_word_valid === 1'h1 && tx_word_ready === 1'h1) begin
            chk("tx_word", tx_word, tw[i]);
            i++;
         end
      end
      chk("tx_busy", 32'(tx_fetch_busy), 32'h0);
      chk("tx_count", 32'(i), 32'hA);
      close_out();
   end
endmodule : testbench
